// *** src/cpcsr_defines.vh ***
// Address map, field layout, reset values and codes of the platform CSR bank
`ifndef CPCSR_DEFINES_VH
`define CPCSR_DEFINES_VH

// ==========================================
// CSR addresses
`define CPCSR_ADDR_W 12
`define CPCSR_REGION_ATTR_ADDR 12'h7c0
`define CPCSR_SYNC_TRIG_ADDR 12'h7c4
`define CPCSR_ERR_UNLOCK_ADDR 12'hbc0
`define CPCSR_ERR_ADDR_ADDR 12'hfc0

// ==========================================
// Field layout
`define CPCSR_NUM_REGIONS 16
`define CPCSR_TRIG_DFENCE_BIT 1
`define CPCSR_TRIG_IFENCE_BIT 0

// ==========================================
// Reset values
`define CPCSR_REGION_ATTR_RST 32'h0000_0000
`define CPCSR_ERR_ADDR_RST 32'h0000_0000

// ==========================================
// Access outcome codes
`define CPCSR_RSP_W 2
`define CPCSR_RSP_OK 2'h0
`define CPCSR_RSP_ILLEGAL 2'h1

// ==========================================
// Error capture states
`define CPCSR_ST_OPEN 1'b0
`define CPCSR_ST_LOCKED 1'b1

`endif

// *** src/cpcsr_region_pair.v ***
// Legalising storage for one region's side-effect / cacheable pair
`timescale 1ns/100ps
`include "cpcsr_defines.vh"

module cpcsr_region_pair
(
  input wire clk_i,
  input wire rst_i,
  input wire wr_i,
  input wire [1:0] wdata_i,
  output wire [1:0] attr_o
);

  reg [1:0] attr_q;
  reg [1:0] attr_d;

  always @*
  begin
    attr_d = attr_q;
    if (wr_i)
    begin
      // Illegal 11 folds to side effect without caching
      if (wdata_i == 2'b11) // R06
        attr_d = 2'b10;
      else
        attr_d = wdata_i; // R02
    end
  end

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      attr_q <= 2'b00; // R05
    else
      attr_q <= attr_d;
  end

  assign attr_o = attr_q;

endmodule

// *** src/cpcsr_err_capture.v ***
// First data-bus error address capture with lock and NMI gating
`timescale 1ns/100ps
`include "cpcsr_defines.vh"

module cpcsr_err_capture
(
  input wire clk_i,
  input wire rst_i,
  input wire err_i,
  input wire [31:0] err_addr_i,
  input wire unlock_i,
  output wire locked_o,
  output wire nmi_req_o,
  output wire [31:0] addr_o
);

  localparam ST_OPEN = 1'b0;
  localparam ST_LOCKED = 1'b1;

  reg state_q;
  reg state_d;
  reg [31:0] addr_q;
  reg [31:0] addr_d;
  reg nmi_q;
  reg nmi_d;

  always @*
  begin
    state_d = state_q;
    addr_d = addr_q;
    nmi_d = 1'b0;
    case (state_q)
      ST_OPEN:
      begin
        if (err_i)
        begin
          addr_d = err_addr_i; // R15
          state_d = ST_LOCKED;
          nmi_d = 1'b1;
        end
      end
      ST_LOCKED:
      begin
        // Unlock first, so a same-cycle error is captured afresh
        if (unlock_i) // R17 R18
        begin
          if (err_i) // R22
          begin
            addr_d = err_addr_i;
            nmi_d = 1'b1;
          end
          else
            state_d = ST_OPEN;
        end
        // Else later errors are dropped and raise no NMI
      end
      default:
        state_d = ST_OPEN;
    endcase
  end

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_OPEN; // R17
      addr_q <= `CPCSR_ERR_ADDR_RST; // R20
      nmi_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      addr_q <= addr_d;
      nmi_q <= nmi_d; // R16
    end
  end

  assign locked_o = state_q;
  assign nmi_req_o = nmi_q;
  assign addr_o = addr_q;

endmodule

// *** src/cpcsr_bank.v ***
// Platform CSR bank: region attributes, sync triggers, bus error capture
//
// Functional notes
// R01 - Reserved and unused bits always read zero.
// R02 - Read/write registers accept any write, hold only legal values.
// R03 - Sixteen regions; side-effect at bit Y*2+1, cacheable at Y*2.
// R04 - Side-effect zero means idempotent, one means side effects possible.
// R05 - Cacheable one allows caching; all region bits reset to zero.
// R06 - Writing pair 11 stores 10 instead.
// R07 - Side-effect ignored for local memories, interrupt controller, all fetches.
// R08 - Cacheable ignored only for fetches from local instruction memory.
// R09 - Software fences after changing region attributes.
// R10 - Region attribute register is read/write at 0x7c0.
// R11 - Sync trigger register debug-mode only; machine access is illegal.
// R12 - Bit 1 starts data fence; bit 0 starts instruction fence.
// R13 - Trigger bits act on written one and read zero.
// R14 - Sync trigger at 0x7c4, bits 31:2 read zero, reset zero.
// R15 - First bus store/load error latches 32-bit address and locks.
// R16 - While locked, bus errors raise no NMI; external NMIs unaffected.
// R17 - Lock released by core reset or unlock register write.
// R18 - Unlock write re-enables NMI for the next bus error.
// R19 - Unlock register at 0xbc0 takes any write, reads zero.
// R20 - Error address register is read-only at 0xfc0, resets zero.
// R21 - Each trigger write gives one-cycle pulse; zero bits do nothing.
// R22 - Error in same cycle as unlock write counts after the unlock.
`timescale 1ns/100ps
`include "cpcsr_defines.vh"

module cpcsr_bank
#(
  parameter NUM_REGIONS = `CPCSR_NUM_REGIONS
)
(
  input wire clk_i,
  input wire rst_i,
  // CSR access port from the pipeline
  input wire csr_rd_i,
  input wire csr_wr_i,
  input wire [11:0] csr_addr_i,
  input wire [31:0] csr_wdata_i,
  input wire debug_mode_i,
  output reg [31:0] csr_rdata_o,
  output reg csr_illegal_o,
  output reg csr_hit_o,
  // Region attribute lookup for a memory access
  input wire [31:0] acc_addr_i,
  input wire acc_fetch_i,
  input wire acc_local_imem_i,
  input wire acc_local_dmem_i,
  input wire acc_intc_i,
  output reg acc_side_effect_o,
  output reg acc_cacheable_o,
  output reg [2*NUM_REGIONS-1:0] region_attr_o,
  // Synchronisation requests
  output reg dfence_req_o,
  output reg ifence_req_o,
  // Data-bus error capture
  input wire bus_err_i,
  input wire [31:0] bus_err_addr_i,
  output reg bus_err_nmi_o,
  output reg err_locked_o
);

  // ==========================================
  // Address decode
  wire acc_any;
  reg hit_attr;
  reg hit_trig;
  reg hit_unlk;
  reg hit_eadr;
  reg known;
  reg bad;
  wire trig_ok;
  wire wr_ok;
  wire attr_wr;
  wire unlock_wr;

  assign acc_any = csr_rd_i | csr_wr_i;

  always @*
  begin
    hit_attr = 1'b0;
    hit_trig = 1'b0;
    hit_unlk = 1'b0;
    hit_eadr = 1'b0;
    case (csr_addr_i)
      `CPCSR_REGION_ATTR_ADDR:
        hit_attr = 1'b1; // R10
      `CPCSR_SYNC_TRIG_ADDR:
        hit_trig = 1'b1; // R14
      `CPCSR_ERR_UNLOCK_ADDR:
        hit_unlk = 1'b1; // R19
      `CPCSR_ERR_ADDR_ADDR:
        hit_eadr = 1'b1; // R20
      default:
        hit_attr = 1'b0;
    endcase
  end

  // Refused accesses change no state and read zero
  always @*
  begin
    known = hit_attr | hit_trig | hit_unlk | hit_eadr;
    bad = 1'b0;
    // Trigger register reachable from debug mode only
    if (hit_trig & ~debug_mode_i)
      bad = 1'b1; // R11
    // The read-only error address refuses writes
    if (hit_eadr & csr_wr_i)
      bad = 1'b1; // R20
  end

  assign trig_ok = hit_trig & debug_mode_i; // R11
  assign wr_ok = csr_wr_i & ~bad;
  assign attr_wr = wr_ok & hit_attr;
  assign unlock_wr = wr_ok & hit_unlk; // R17 R19

  // ==========================================
  // Region attribute storage
  wire [2*NUM_REGIONS-1:0] attr_w;

  genvar g;
  generate
    for (g = 0; g < NUM_REGIONS; g = g + 1)
    begin : g_region
      cpcsr_region_pair u_pair
      (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wr_i(attr_wr),
        .wdata_i(csr_wdata_i[2*g+1:2*g]), // R03
        .attr_o(attr_w[2*g+1:2*g])
      );
    end
  endgenerate

  // ==========================================
  // Error capture
  wire [31:0] eaddr_w;
  wire nmi_w;
  wire locked_w;

  cpcsr_err_capture u_err
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .err_i(bus_err_i),
    .err_addr_i(bus_err_addr_i),
    .unlock_i(unlock_wr),
    .locked_o(locked_w),
    .nmi_req_o(nmi_w),
    .addr_o(eaddr_w)
  );

  // ==========================================
  // Region lookup
  wire [3:0] reg_idx = acc_addr_i[31:28];
  wire se_raw = attr_w[{reg_idx, 1'b1}];
  wire ca_raw = attr_w[{reg_idx, 1'b0}];
  reg side_d;
  reg cache_d;

  always @*
  begin
    side_d = se_raw; // R04
    cache_d = ca_raw; // R05
    // Local targets and fetches never see side effects
    if (acc_fetch_i | acc_local_imem_i | acc_local_dmem_i | acc_intc_i)
      side_d = 1'b0; // R07
    // Local instruction memory fetches are always cacheable-agnostic
    if (acc_fetch_i & acc_local_imem_i)
      cache_d = 1'b0; // R08
  end

  // ==========================================
  // Read data
  reg [31:0] rdata_d;

  always @*
  begin
    rdata_d = 32'h0000_0000; // R01
    if (csr_rd_i & ~bad)
    begin
      case (csr_addr_i)
        `CPCSR_REGION_ATTR_ADDR:
          rdata_d[2*NUM_REGIONS-1:0] = attr_w; // R03
        `CPCSR_ERR_ADDR_ADDR:
          rdata_d = eaddr_w; // R20
        // Trigger and unlock registers read zero
        `CPCSR_SYNC_TRIG_ADDR, `CPCSR_ERR_UNLOCK_ADDR:
          rdata_d = 32'h0000_0000; // R13 R19
        default:
          rdata_d = 32'h0000_0000; // R01
      endcase
    end
  end

  // ==========================================
  // Access outcome and trigger pulses
  reg illegal_d;
  reg hit_d;
  reg dfence_d;
  reg ifence_d;

  always @*
  begin
    illegal_d = 1'b0;
    hit_d = 1'b0;
    if (acc_any)
    begin
      if (bad | ~known)
        illegal_d = 1'b1; // R11
      else
        hit_d = 1'b1;
    end
  end

  // One-cycle pulse per write carrying a one
  always @*
  begin
    dfence_d = 1'b0;
    ifence_d = 1'b0;
    if (wr_ok & trig_ok)
    begin
      dfence_d = csr_wdata_i[`CPCSR_TRIG_DFENCE_BIT]; // R12 R21
      ifence_d = csr_wdata_i[`CPCSR_TRIG_IFENCE_BIT]; // R12 R21
    end
  end

  // ==========================================
  // Output registers
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      csr_rdata_o <= 32'h0000_0000;
    end
    else
    begin
      csr_rdata_o <= rdata_d;
    end
  end

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      csr_illegal_o <= 1'b0;
    end
    else
    begin
      csr_illegal_o <= illegal_d;
    end
  end

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      csr_hit_o <= 1'b0;
    end
    else
    begin
      csr_hit_o <= hit_d;
    end
  end

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      acc_side_effect_o <= 1'b0;
    end
    else
    begin
      acc_side_effect_o <= side_d;
    end
  end

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      acc_cacheable_o <= 1'b0;
    end
    else
    begin
      acc_cacheable_o <= cache_d;
    end
  end

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      region_attr_o <= {2*NUM_REGIONS{1'b0}};
    end
    else
    begin
      region_attr_o <= attr_w;
    end
  end

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dfence_req_o <= 1'b0;
    end
    else
    begin
      dfence_req_o <= dfence_d; // R21
    end
  end

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ifence_req_o <= 1'b0;
    end
    else
    begin
      ifence_req_o <= ifence_d; // R21
    end
  end

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      bus_err_nmi_o <= 1'b0;
    end
    else
    begin
      bus_err_nmi_o <= nmi_w; // R16
    end
  end

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      err_locked_o <= 1'b0;
    end
    else
    begin
      err_locked_o <= locked_w;
    end
  end

endmodule

// *** verif/cpcsr_props.sv ***
// Assertions on the platform CSR bank ports
`timescale 1ns/100ps
module cpcsr_props
(
  input wire clk_i,
  input wire rst_i,
  input wire csr_rd_i,
  input wire csr_wr_i,
  input wire [11:0] csr_addr_i,
  input wire [31:0] csr_wdata_i,
  input wire debug_mode_i,
  input wire [31:0] csr_rdata_o,
  input wire csr_illegal_o,
  input wire [31:0] region_attr_o,
  input wire dfence_req_o,
  input wire ifence_req_o,
  input wire bus_err_i,
  input wire bus_err_nmi_o,
  input wire err_locked_o
);
  wire tw = csr_wr_i && csr_addr_i == 12'h7c4 && debug_mode_i;
  wire tm = csr_wr_i && csr_addr_i == 12'h7c4 && !debug_mode_i;
  wire unl = csr_wr_i && csr_addr_i == 12'hbc0;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ====================
  // Properties
  trig_map_a: assert property (tw |=>
    {dfence_req_o, ifence_req_o} == $past(csr_wdata_i[1:0])) else $error("fence map");
  trig_cause_a: assert property (dfence_req_o || ifence_req_o |-> $past(tw))
    else $error("stray fence");
  trig_refuse_a: assert property (tm |=> csr_illegal_o && !dfence_req_o && !ifence_req_o)
    else $error("machine trigger");
  ro_write_a: assert property (csr_wr_i && csr_addr_i == 12'hfc0 |=> csr_illegal_o)
    else $error("ro write");
  pair_legal_a: assert property ((region_attr_o & (region_attr_o >> 1) & 32'h5555_5555) == 0)
    else $error("pair 11");
  first_err_a: assert property (bus_err_i && !err_locked_o && !$past(bus_err_i) |->
    ##2 bus_err_nmi_o && err_locked_o) else $error("no capture");
  err_gate_a: assert property (bus_err_i && err_locked_o && !unl && !$past(unl) |->
    ##2 !bus_err_nmi_o) else $error("nmi not gated");
  lock_rel_a: assert property ($fell(err_locked_o) |-> $past(unl, 2))
    else $error("lock dropped");
  zero_read_a: assert property (csr_rd_i && (csr_addr_i == 12'h7c4 || csr_addr_i == 12'hbc0) |=>
    csr_rdata_o == 0) else $error("trigger or unlock read not zero");
endmodule
bind cpcsr_bank cpcsr_props props
(
  .clk_i(clk_i),
  .rst_i(rst_i),
  .csr_rd_i(csr_rd_i),
  .csr_wr_i(csr_wr_i),
  .csr_addr_i(csr_addr_i),
  .csr_wdata_i(csr_wdata_i),
  .debug_mode_i(debug_mode_i),
  .csr_rdata_o(csr_rdata_o),
  .csr_illegal_o(csr_illegal_o),
  .region_attr_o(region_attr_o),
  .dfence_req_o(dfence_req_o),
  .ifence_req_o(ifence_req_o),
  .bus_err_i(bus_err_i),
  .bus_err_nmi_o(bus_err_nmi_o),
  .err_locked_o(err_locked_o)
);

// *** verif/cpcsr_bank_test.sv ***
// Testbench for the platform CSR bank
`timescale 1ns/100ps
module cpcsr_bank_test;
  logic clk_i, rst_i, csr_rd_i, csr_wr_i, debug_mode_i, bus_err_i;
  logic acc_fetch_i, acc_local_imem_i, acc_local_dmem_i, acc_intc_i;
  logic [11:0] csr_addr_i;
  logic [31:0] csr_wdata_i, acc_addr_i, bus_err_addr_i, csr_rdata_o, region_attr_o;
  logic csr_illegal_o, csr_hit_o, acc_side_effect_o, acc_cacheable_o;
  logic dfence_req_o, ifence_req_o, bus_err_nmi_o, err_locked_o;
  int error_cnt = 0;
  int compares = 0;
  cpcsr_bank dut
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .csr_rd_i(csr_rd_i),
    .csr_wr_i(csr_wr_i),
    .csr_addr_i(csr_addr_i),
    .csr_wdata_i(csr_wdata_i),
    .debug_mode_i(debug_mode_i),
    .csr_rdata_o(csr_rdata_o),
    .csr_illegal_o(csr_illegal_o),
    .csr_hit_o(csr_hit_o),
    .acc_addr_i(acc_addr_i),
    .acc_fetch_i(acc_fetch_i),
    .acc_local_imem_i(acc_local_imem_i),
    .acc_local_dmem_i(acc_local_dmem_i),
    .acc_intc_i(acc_intc_i),
    .acc_side_effect_o(acc_side_effect_o),
    .acc_cacheable_o(acc_cacheable_o),
    .region_attr_o(region_attr_o),
    .dfence_req_o(dfence_req_o),
    .ifence_req_o(ifence_req_o),
    .bus_err_i(bus_err_i),
    .bus_err_addr_i(bus_err_addr_i),
    .bus_err_nmi_o(bus_err_nmi_o),
    .err_locked_o(err_locked_o)
  );
  // ====================
  // Checks and drivers
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask
  task acc(input logic r, input logic [11:0] a, input logic [31:0] d, e, input logic il);
    @(posedge clk_i);
    csr_rd_i <= r;
    csr_wr_i <= !r;
    csr_addr_i <= a;
    csr_wdata_i <= d;
    @(posedge clk_i);
    csr_rd_i <= 1'h0;
    csr_wr_i <= 1'h0;
    #1;
    chk("rdata", e, csr_rdata_o);
    chk("illegal", il, csr_illegal_o);
    chk("hit", !il, csr_hit_o);
  endtask
  // Optional unlock write lands in the same cycle as the error
  task err(input logic [31:0] a, input logic un, input logic n);
    @(posedge clk_i);
    bus_err_i <= 1'h1;
    bus_err_addr_i <= a;
    csr_wr_i <= un;
    csr_addr_i <= 12'hbc0;
    @(posedge clk_i);
    bus_err_i <= 1'h0;
    bus_err_addr_i <= ~a;
    csr_wr_i <= 1'h0;
    @(posedge clk_i);
    #1;
    chk("nmi", n, bus_err_nmi_o);
    chk("locked", 1'h1, err_locked_o);
  endtask
  task lk(input logic [3:0] g, input logic [3:0] f, input logic [1:0] e);
    @(posedge clk_i);
    acc_addr_i <= {g, 28'h123_4567};
    {acc_fetch_i, acc_local_imem_i, acc_local_dmem_i, acc_intc_i} <= f;
    @(posedge clk_i);
    #1;
    chk("lookup", e, {acc_side_effect_o, acc_cacheable_o});
  endtask
  function logic [31:0] legal(input logic [31:0] x);
    return x & ~((x >> 1) & 32'h5555_5555);
  endfunction
  task stop_test;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end
  // ====================
  // Main sequence
  initial
  begin
    rst_i = 1'h1;
    {csr_rd_i, csr_wr_i, debug_mode_i, bus_err_i, csr_addr_i, csr_wdata_i} = '0;
    {acc_fetch_i, acc_local_imem_i, acc_local_dmem_i, acc_intc_i} = '0;
    {acc_addr_i, bus_err_addr_i} = '0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'h0;
    acc(1, 12'h7c0, 0, 0, 0);
    acc(1, 12'hfc0, 0, 0, 0);
    acc(1, 12'h7c8, 0, 0, 1);
    acc(0, 12'hfc0, 32'h1, 0, 1);
    acc(0, 12'h7c0, 32'hffff_ffff, 0, 0);
    acc(1, 12'h7c0, 0, legal(32'hffff_ffff), 0);
    acc(0, 12'h7c0, 32'h0000_c480, 0, 0);
    acc(1, 12'h7c0, 0, legal(32'h0000_c480), 0);
    chk("attr", legal(32'h0000_c480), region_attr_o);
    @(posedge clk_i);
    debug_mode_i <= 1'h1;
    acc(0, 12'h7c4, 32'h3, 0, 0);
    lk(4'h3, 4'h0, 2'h2);
    lk(4'h3, 4'h8, 2'h0);
    lk(4'h3, 4'h2, 2'h0);
    lk(4'h3, 4'h1, 2'h0);
    lk(4'h5, 4'h8, 2'h1);
    lk(4'h5, 4'hc, 2'h0);
    lk(4'h5, 4'h4, 2'h1);
    lk(4'h7, 4'h0, 2'h2);
    for (int i = 0; i < 4; i++)
    begin
      acc(0, 12'h7c4, i, 0, 0);
      chk("fence", i, {dfence_req_o, ifence_req_o});
    end
    acc(1, 12'h7c4, 0, 0, 0);
    @(posedge clk_i);
    debug_mode_i <= 1'h0;
    acc(0, 12'h7c4, 32'h3, 0, 1);
    chk("fence", 0, {dfence_req_o, ifence_req_o});
    err(32'hdead_0010, 0, 1);
    err(32'h5a5a_0020, 0, 0);
    acc(1, 12'hfc0, 0, 32'hdead_0010, 0);
    acc(0, 12'hbc0, 32'hffff_ffff, 0, 0);
    acc(1, 12'hbc0, 0, 0, 0);
    chk("locked", 0, err_locked_o);
    err(32'h0f0f_0030, 0, 1);
    err(32'h1111_0040, 1, 1);
    acc(1, 12'hfc0, 0, 32'h1111_0040, 0);
    @(posedge clk_i);
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    acc(1, 12'hfc0, 0, 0, 0);
    chk("locked", 0, err_locked_o);
    stop_test;
  end
endmodule
